// File: hdl/sclks_top.sv
/*
 System clock source selector: mode decode, start-up timer, clock output
 divider, pin routing and the oscillator trim register behind an APB slave.
 Assumes RST is a power-on or brown-out reset, MASTER_CLEAR_RST is a
 master-clear or watchdog reset, and OSC_PIN_ONE_I is the oscillator sampled
 synchronously with CLK. The source clock may stall; all state is static.
*/
// Register access over APB and the placing of the registers were left to the implementer.
// Behaviour
// - Clock source comes from the mode field of the configuration word.
// - The mode field selects one of eight clock modes.
// - Resonator modes count 1024 oscillator cycles after reset, power-up timer, wake.
// - While the start-up timer counts, execution is held.
// - External clock mode skips the start-up delay entirely.
// - External clock mode: pin one is clock input, pin two is I/O.
// - A stopped external clock halts the device with state retained.
// - Resonator modes drive low, medium or high amplifier gain.
// - RC clock-out mode drives pin two with oscillator divided by four.
// - RC I/O mode keeps RC on pin one, pin two is I/O.
// - Internal oscillator runs at 4 or 8 MHz by one select bit.
// - Internal clock-out mode: pin one I/O, pin two outputs frequency over four.
// - Internal I/O mode releases both pins to I/O.
// - Trim register holds 5-bit signed value, upper bits read zero.
// - Trim 01111 is fastest, 00000 calibrated, 10000 slowest, monotonic.
// - Trim writes shift frequency without stalling; no completion flag.
// - Trim clears on power-on or brown-out, kept on master clear.
`default_nettype none
module sclks_top
    import sclks_pkg::*;
#(
    parameter int POWER_UP_CYCLES = SCLKS_POWER_UP_CYCLES,
    parameter int STARTUP_CYCLES = SCLKS_STARTUP_CYCLES
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic MASTER_CLEAR_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic OSC_PIN_ONE_I,
    output logic OSC_PIN_TWO_O,
    output logic OSC_PIN_TWO_OE,
    output logic OSC_PIN_ONE_GPIO,
    output logic OSC_PIN_TWO_GPIO,
    output logic [1:0] AMP_GAIN,
    output logic INTERNAL_FREQ_8MHZ,
    output logic INTERNAL_OSC_EN,
    output logic [4:0] TRIM_VALUE,
    output logic EXEC_HOLD
);
    initial begin
        if (STARTUP_CYCLES < 1 || STARTUP_CYCLES > 65535 || POWER_UP_CYCLES < 1
            || POWER_UP_CYCLES > 65535) begin
            $error("sclks_top: timer counts out of range");
        end
    end

    typedef enum logic [2:0] {
        SCLKS_ST_POWER_UP,
        SCLKS_ST_STARTUP,
        SCLKS_ST_RUN,
        SCLKS_ST_SLEEP
    } sclks_state_t;

    sclks_state_t state_reg, state_next;
    logic [2:0] mode_reg;
    logic freq_sel_reg;
    logic put_en_reg;
    logic [4:0] trim_value_reg;
    logic [15:0] count_reg, count_next;
    logic osc_prev_reg;
    logic [1:0] div_reg;
    logic clkout_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [1:0] gain_reg;
    logic pin_one_gpio_reg, pin_two_gpio_reg, pin_two_oe_reg, int_en_reg;

    function automatic logic is_resonator(input logic [2:0] m);
        return m == SCLKS_LOW_GAIN_RESONATOR_MODE || m == SCLKS_MEDIUM_GAIN_RESONATOR_MODE
            || m == SCLKS_HIGH_GAIN_RESONATOR_MODE;
    endfunction

    function automatic logic is_internal(input logic [2:0] m);
        return m == SCLKS_INTERNAL_IO_MODE || m == SCLKS_INTERNAL_CLKOUT_MODE;
    endfunction

    // Read data and error are latched in the first access cycle and stand with the
    // one-wait-state ready; a write commits only at the edge that completes the transfer.
    wire logic apb_access = PSEL && PENABLE && !pready_reg;
    wire logic wr = PSEL && PENABLE && pready_reg && PWRITE;
    wire logic hit_trim = PADDR == SCLKS_TRIM_OFFSET;
    wire logic hit_cfg = PADDR == SCLKS_CONFIG_OFFSET;
    wire logic hit_stat = PADDR == SCLKS_STATUS_OFFSET;
    wire logic hit_ctl = PADDR == SCLKS_CONTROL_OFFSET;
    wire logic mapped = hit_trim || hit_cfg || hit_stat || hit_ctl;
    wire logic wr_trim = wr && hit_trim && PSTRB[0];
    wire logic wr_cfg = wr && hit_cfg && PSTRB[0];
    wire logic wr_ctl = wr && hit_ctl && PSTRB[0];
    wire logic sleep_req = wr_ctl && PWDATA[SCLKS_CTL_SLEEP_BIT];
    wire logic wake_req = wr_ctl && PWDATA[SCLKS_CTL_WAKE_BIT];
    wire logic osc_rise = OSC_PIN_ONE_I && !osc_prev_reg;
    wire logic [2:0] mode_next = PWDATA[SCLKS_CFG_MODE_LSB +: 3];

    wire logic [31:0] rd_mux = hit_trim ? {27'h000_0000, trim_value_reg} :
        hit_cfg ? {27'h000_0000, put_en_reg, freq_sel_reg, mode_reg} :
        hit_stat ? {29'h0000_0000, state_reg} : 32'h0000_0000;

    always_ff @(posedge CLK) begin
        if (RST) begin
            trim_value_reg <= SCLKS_TRIM_RESET;
        end else if (wr_trim) begin
            trim_value_reg <= PWDATA[4:0];
        end
    end

    // Configuration survives master clear like the rest of the static state.
    always_ff @(posedge CLK) begin
        if (RST) begin
            mode_reg <= SCLKS_MODE_RESET;
            freq_sel_reg <= 1'b0;
            put_en_reg <= 1'b0;
        end else if (wr_cfg) begin
            mode_reg <= mode_next;
            freq_sel_reg <= PWDATA[SCLKS_CFG_FREQ_BIT];
            put_en_reg <= PWDATA[SCLKS_CFG_PUT_BIT];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= PSEL && PENABLE && !pready_reg;
            pslverr_reg <= apb_access && !mapped;
            prdata_reg <= (apb_access && !PWRITE) ? rd_mux : 32'h0000_0000;
        end
    end

    // The start-up timer counts pin-one rising edges; a stalled source simply freezes it.
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        case (state_reg)
            SCLKS_ST_POWER_UP: begin
                if (!put_en_reg || count_reg >= 16'(POWER_UP_CYCLES - 1)) begin
                    count_next = 16'h0000;
                    state_next = is_resonator(mode_reg) ? SCLKS_ST_STARTUP : SCLKS_ST_RUN;
                end else begin
                    count_next = count_reg + 16'h0001;
                end
            end
            SCLKS_ST_STARTUP: begin
                if (osc_rise) begin
                    if (count_reg >= 16'(STARTUP_CYCLES - 1)) begin
                        count_next = 16'h0000;
                        state_next = SCLKS_ST_RUN;
                    end else begin
                        count_next = count_reg + 16'h0001;
                    end
                end
            end
            SCLKS_ST_RUN: begin
                if (sleep_req) begin
                    state_next = SCLKS_ST_SLEEP;
                end
            end
            default: begin
                if (wake_req) begin
                    count_next = 16'h0000;
                    state_next = is_resonator(mode_reg) ? SCLKS_ST_STARTUP : SCLKS_ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_reg <= SCLKS_ST_POWER_UP;
            count_reg <= 16'h0000;
            osc_prev_reg <= 1'b0;
            div_reg <= 2'h0;
            clkout_reg <= 1'b0;
            EXEC_HOLD <= 1'b1;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            osc_prev_reg <= OSC_PIN_ONE_I;
            // The holding state retains all of its content while the clock is stopped.
            EXEC_HOLD <= state_next != SCLKS_ST_RUN || MASTER_CLEAR_RST;
            if (osc_rise) begin
                div_reg <= div_reg + 2'h1;
                if (div_reg == 2'(SCLKS_CLKOUT_DIV / 2 - 1) || div_reg == 2'(SCLKS_CLKOUT_DIV - 1)) begin
                    clkout_reg <= !clkout_reg;
                end
            end
        end
    end

    // Pin and amplifier routing per mode.
    always_comb begin
        gain_reg = SCLKS_GAIN_OFF;
        pin_one_gpio_reg = 1'b0;
        pin_two_gpio_reg = 1'b0;
        pin_two_oe_reg = 1'b0;
        int_en_reg = 1'b0;
        case (mode_reg)
            SCLKS_LOW_GAIN_RESONATOR_MODE: gain_reg = SCLKS_GAIN_LOW;
            SCLKS_MEDIUM_GAIN_RESONATOR_MODE: gain_reg = SCLKS_GAIN_MEDIUM;
            SCLKS_HIGH_GAIN_RESONATOR_MODE: gain_reg = SCLKS_GAIN_HIGH;
            SCLKS_EXTERNAL_CLOCK_MODE: pin_two_gpio_reg = 1'b1;
            SCLKS_RESISTOR_CAP_IO_MODE: pin_two_gpio_reg = 1'b1;
            SCLKS_RESISTOR_CAP_CLKOUT_MODE: pin_two_oe_reg = 1'b1;
            SCLKS_INTERNAL_CLKOUT_MODE: begin
                pin_one_gpio_reg = 1'b1;
                pin_two_oe_reg = 1'b1;
                int_en_reg = 1'b1;
            end
            default: begin
                pin_one_gpio_reg = 1'b1;
                pin_two_gpio_reg = 1'b1;
                int_en_reg = 1'b1;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            OSC_PIN_TWO_O <= 1'b0;
            OSC_PIN_TWO_OE <= 1'b0;
            OSC_PIN_ONE_GPIO <= 1'b0;
            OSC_PIN_TWO_GPIO <= 1'b1;
            AMP_GAIN <= SCLKS_GAIN_OFF;
            INTERNAL_FREQ_8MHZ <= 1'b0;
            INTERNAL_OSC_EN <= 1'b0;
            TRIM_VALUE <= SCLKS_TRIM_RESET;
        end else begin
            OSC_PIN_TWO_O <= pin_two_oe_reg && clkout_reg;
            OSC_PIN_TWO_OE <= pin_two_oe_reg;
            OSC_PIN_ONE_GPIO <= pin_one_gpio_reg;
            OSC_PIN_TWO_GPIO <= pin_two_gpio_reg;
            AMP_GAIN <= gain_reg;
            INTERNAL_FREQ_8MHZ <= freq_sel_reg;
            INTERNAL_OSC_EN <= int_en_reg && is_internal(mode_reg);
            // Signed trim goes straight to the oscillator; higher code, higher rate.
            TRIM_VALUE <= trim_value_reg;
        end
    end

    assign PRDATA = prdata_reg;
    assign PREADY = pready_reg;
    assign PSLVERR = pslverr_reg;
endmodule
`default_nettype wire

// File: shared/sclks_pkg.sv
/*
 Package for the system clock source selector: register offsets, field layout,
 mode encoding, reset values and timing constants.
 Assumes a 100 MHz block clock and a 32-bit APB register bus.
*/
`default_nettype none
package sclks_pkg;
    typedef enum logic [2:0] {
        SCLKS_LOW_GAIN_RESONATOR_MODE,
        SCLKS_MEDIUM_GAIN_RESONATOR_MODE,
        SCLKS_HIGH_GAIN_RESONATOR_MODE,
        SCLKS_EXTERNAL_CLOCK_MODE,
        SCLKS_RESISTOR_CAP_IO_MODE,
        SCLKS_RESISTOR_CAP_CLKOUT_MODE,
        SCLKS_INTERNAL_IO_MODE,
        SCLKS_INTERNAL_CLKOUT_MODE
    } sclks_mode_t;

    typedef enum logic [1:0] {
        SCLKS_GAIN_OFF,
        SCLKS_GAIN_LOW,
        SCLKS_GAIN_MEDIUM,
        SCLKS_GAIN_HIGH
    } sclks_gain_t;

    localparam logic [11:0] SCLKS_TRIM_OFFSET = 12'h000;
    localparam logic [11:0] SCLKS_CONFIG_OFFSET = 12'h004;
    localparam logic [11:0] SCLKS_STATUS_OFFSET = 12'h008;
    localparam logic [11:0] SCLKS_CONTROL_OFFSET = 12'h00C;

    localparam int SCLKS_TRIM_WIDTH = 5;
    localparam logic [4:0] SCLKS_TRIM_RESET = 5'h00;
    localparam logic [2:0] SCLKS_MODE_RESET = 3'h3;
    localparam int SCLKS_CFG_MODE_LSB = 0;
    localparam int SCLKS_CFG_FREQ_BIT = 3;
    localparam int SCLKS_CFG_PUT_BIT = 4;
    localparam int SCLKS_CTL_SLEEP_BIT = 0;
    localparam int SCLKS_CTL_WAKE_BIT = 1;

    localparam int SCLKS_STARTUP_CYCLES = 1024;
    localparam int SCLKS_CLKOUT_DIV = 4;
    localparam int SCLKS_CLK_MHZ = 100;
    localparam int SCLKS_POWER_UP_TIME_US = 72;
    localparam int SCLKS_POWER_UP_CYCLES = SCLKS_POWER_UP_TIME_US * SCLKS_CLK_MHZ;
endpackage
`default_nettype wire

// File: verif/sclks_properties.sv
/* Port checker for sclks_top, bound to every instance.
 Assumes the design's package and one clock domain. */
`default_nettype none
module sclks_properties
    import sclks_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic MASTER_CLEAR_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic OSC_PIN_TWO_O,
    input wire logic OSC_PIN_TWO_OE,
    input wire logic OSC_PIN_ONE_GPIO,
    input wire logic OSC_PIN_TWO_GPIO,
    input wire logic [1:0] AMP_GAIN,
    input wire logic INTERNAL_OSC_EN,
    input wire logic [4:0] TRIM_VALUE,
    input wire logic EXEC_HOLD
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    sequence setup_s;
        PSEL && !PENABLE;
    endsequence
    sequence access_s;
        PSEL && PENABLE;
    endsequence
    chk_ready_wait: assert property (setup_s ##1 access_s |=> PREADY)
        else $error("ready missing after one wait");
    chk_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready too long");
    chk_idle_quiet: assert property (!PSEL |-> !PREADY && !PSLVERR) else $error("idle answer");
    chk_err_ready: assert property (PSLVERR |-> PREADY) else $error("error without ready");
    // The reset clause is switched off so that the reset itself is watched.
    chk_trim_clear: assert property (disable iff (1'b0) RST |=> TRIM_VALUE == 5'h00)
        else $error("trim not cleared");
    chk_trim_keep: assert property (MASTER_CLEAR_RST |=> $stable(TRIM_VALUE))
        else $error("trim lost on master clear");
    chk_master_clear_reset_hold: assert property (MASTER_CLEAR_RST |=> EXEC_HOLD) else $error("no hold");
    chk_trim_nostall: assert property (PSEL && PENABLE && PWRITE && PADDR == 12'h000
        && !EXEC_HOLD && !MASTER_CLEAR_RST |=> !EXEC_HOLD) else $error("trim write stalls");
    chk_clkout_quiet: assert property (!OSC_PIN_TWO_OE |-> !OSC_PIN_TWO_O)
        else $error("clock out while off");
    chk_gain_pins: assert property (AMP_GAIN != SCLKS_GAIN_OFF |-> !OSC_PIN_TWO_GPIO
        && !OSC_PIN_ONE_GPIO && !INTERNAL_OSC_EN) else $error("resonator pins wrong");
    chk_clkout_pin: assert property (OSC_PIN_TWO_OE |-> !OSC_PIN_TWO_GPIO)
        else $error("pin two both ways");
endmodule
bind sclks_top sclks_properties i_sclks_properties (.*);
`default_nettype wire

// File: verif/sclks_osc_model.sv
/* Oscillator on the first pin: toggles every HALF clocks while run is high.
 Assumes changes on the bench clock's rising edge. */
`default_nettype none
module sclks_osc_model #(
    parameter int HALF = 2
) (
    input wire logic clk,
    input wire logic run,
    output logic osc
);
    int cnt = 0;
    initial osc = 1'b0;
    // A stopped oscillator stands still low rather than keeping its phase.
    always @(posedge clk) begin
        if (!run) begin
            cnt <= 0;
            osc <= 1'b0;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            osc <= !osc;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule
`default_nettype wire

// File: verif/tb.sv
/* Self-checking bench for sclks_top with an oscillator model on pin one.
 Assumes small power-up and start-up counts. */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sclks_pkg::*;
    localparam int SU = 8;
    localparam int HALF = 2;
    logic clk, rst, master_clear_reset, psel, pen, pwr, run, pready, pslverr, err;
    logic osc, two_o, two_oe, g1, g2, f8, ien, hold;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [1:0] gain;
    logic [4:0] trim;
    int bad_count, n_checks, n, m;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    sclks_top #(.POWER_UP_CYCLES(4), .STARTUP_CYCLES(SU)) i_sclks_top (.CLK(clk), .RST(rst),
        .MASTER_CLEAR_RST(master_clear_reset), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
        .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .OSC_PIN_ONE_I(osc), .OSC_PIN_TWO_O(two_o), .OSC_PIN_TWO_OE(two_oe),
        .OSC_PIN_ONE_GPIO(g1), .OSC_PIN_TWO_GPIO(g2), .AMP_GAIN(gain),
        .INTERNAL_FREQ_8MHZ(f8), .INTERNAL_OSC_EN(ien), .TRIM_VALUE(trim), .EXEC_HOLD(hold));
    sclks_osc_model #(.HALF(HALF)) i_sclks_osc_model (.clk(clk), .run(run), .osc(osc));
    task report_and_stop;
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    // Ready is sampled at the rising edge; the request stands until that edge.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int i;
        @(posedge clk);
        psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge clk);
        pen <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (i >= 20) begin
            check(0, 1);
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hF);
    endtask
    task rdr(input logic [11:0] a);
        apb(1'b0, a, 32'h0000_0000, 4'hF);
    endtask
    task count_until(input logic on_pin, input logic want);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while ((on_pin ? two_o : hold) !== want && n < 200);
        if (n >= 200) begin
            check(0, 1);
            report_and_stop();
        end
    endtask
    initial begin
        rst = 1'b1; master_clear_reset = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0; run = 1'b0;
        paddr = 12'h000; pwdata = 32'h0000_0000; pstrb = 4'h0; bad_count = 0; n_checks = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        cyc(3);
        check(hold, 0);
        check({two_oe, g1, g2}, 3'b001);
        rdr(SCLKS_TRIM_OFFSET); check(rd, 0);
        rdr(SCLKS_CONFIG_OFFSET); check(rd[2:0], SCLKS_MODE_RESET);
        wr(SCLKS_TRIM_OFFSET, 32'hFFFF_FFEF); rdr(SCLKS_TRIM_OFFSET); check(rd, 32'hF);
        cyc(1); check({hold, trim}, 6'h0F);
        apb(1'b1, SCLKS_TRIM_OFFSET, 32'h10, 4'h0); cyc(2); check(trim, 5'h0F);
        wr(SCLKS_TRIM_OFFSET, 32'h10); cyc(2); check(trim, 5'h10);
        rdr(12'h010); check(err, 1); check(rd, 0);
        for (m = 0; m < 8; m++) begin
            wr(SCLKS_CONFIG_OFFSET, m + 8 * (m % 2)); cyc(2);
            check({gain, two_oe, g1, g2, ien, f8}, {m < 3 ? m[1:0] + 2'h1 : 2'h0, m == 5 ||
                m == 7, m >= 6, m == 3 || m == 4 || m == 6, m >= 6, m[0]});
        end
        wr(SCLKS_CONFIG_OFFSET, 5); run <= 1'b1;
        count_until(1'b1, 1'b1); count_until(1'b1, 1'b0); check(n, 4 * HALF);
        count_until(1'b1, 1'b1); check(n, 4 * HALF);
        wr(SCLKS_CONFIG_OFFSET, 1); wr(SCLKS_CONTROL_OFFSET, 1); run <= 1'b0;
        wr(SCLKS_CONTROL_OFFSET, 2); cyc(20); check(hold, 1);
        rdr(SCLKS_STATUS_OFFSET); check(rd[2:0], 1);
        @(posedge clk); run <= 1'b1;
        count_until(1'b0, 1'b0);
        check(n >= (2 * SU - 1) * HALF && n <= (2 * SU + 2) * HALF, 1);
        wr(SCLKS_CONFIG_OFFSET, 3); wr(SCLKS_CONTROL_OFFSET, 1); wr(SCLKS_CONTROL_OFFSET, 2);
        cyc(3); check(hold, 0);
        wr(SCLKS_TRIM_OFFSET, 5); @(posedge clk); master_clear_reset <= 1'b1; cyc(3); check(hold, 1);
        @(posedge clk); master_clear_reset <= 1'b0; rdr(SCLKS_TRIM_OFFSET); check(rd, 5);
        @(posedge clk); rst <= 1'b1; cyc(2); @(posedge clk); rst <= 1'b0;
        cyc(3); rdr(SCLKS_TRIM_OFFSET); check(rd, 0);
        report_and_stop();
    end
endmodule
`default_nettype wire
